//--- logic/bdc_pkg.sv
/*
 Constants shared by the buffer descriptor chain handler: descriptor
 word offsets, field positions, register offsets and widths.
 Assumes 32-bit descriptor memory and a 32-bit AXI4-Lite bus.
*/
package bdc_pkg;
   // ****************************************
   // Descriptor layout
   // ****************************************
   localparam int DESC_BYTES = 32;
   localparam logic [31:0] OFS_W3 = 32'h0000000c;
   localparam logic [31:0] WORD_STEP = 32'h00000004;
   localparam int RD_WORDS = 5;
   localparam int WB_WORDS = 3;
   localparam int LEN_W = 22;
   localparam int RSV_LSB = 22;
   localparam logic [2:0] K_W3 = 3'h0;
   localparam logic [2:0] K_W4 = 3'h1;
   localparam logic [2:0] K_W5 = 3'h2;
   localparam logic [2:0] K_W6 = 3'h3;
   localparam logic [2:0] K_W7 = 3'h4;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_HEAD = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_BYTES = 8'h0c;
   localparam logic [7:0] REG_DESCS = 8'h10;
   localparam int CTRL_TX = 0;
   localparam int CTRL_RX = 1;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ****************************************
   // Engine states
   // ****************************************
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_DESC = 5'h02,
      S_MOVE = 5'h04,
      S_WBACK = 5'h08,
      S_DROP = 5'h10
   } bdc_state_t;
endpackage

//--- logic/bdc_chain.sv
/*
 Buffer descriptor chain engine: walks linked buffer descriptors in
 shared memory, streams buffer bytes out (transmit) or fills buffers
 from a byte stream and writes descriptor words back (receive).
 Assumes a memory port that answers each held request with a one-cycle
 ack, and an AXI4-Lite master for the control registers.
*/
// How it works
// [R1] Receive writes byte count into length field
// [R2] Length counts bytes from pointer, not before
// [R3] Upper ten bits of word three kept
// [R4] Word four gives the transmit buffer address
// [R5] Receive writes buffer address into word four
// [R6] Receive rewrites the link word
// [R7] Zero link ends the packet chain
// [R8] Word six length read, never written
// [R9] Word seven pointer read, never written
// [R10] Pool index bits ignored by hardware
// [R11] Reference count bits ignored by hardware
// [R12] Chain of descriptors forms one packet
// [R13] Descriptors are 32 bytes, word aligned
// [R14] Receive stops at original buffer length
`timescale 1ns/1ps
module bdc_chain
   import bdc_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   output logic [3:0] mem_be_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_last_i,
   output logic rx_ready_o
);
   import bdc_pkg::*;
   // ****************************************
   // Register bus
   // ****************************************
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [31:0] head_reg;
   logic done_reg, ovf_reg, aln_reg, rx_mode_reg;
   logic [31:0] bytes_reg, descs_reg;
   bdc_state_t state_reg;
   wire aw_hs = s_axi_awvalid_i & s_axi_awready_o;
   wire w_hs = s_axi_wvalid_i & s_axi_wready_o;
   wire commit = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
   wire idle = state_reg == S_IDLE;
   wire ctrl_hit = commit & waddr_reg == REG_CTRL & wstrb_reg[0];
   wire start_tx = ctrl_hit & wdata_reg[CTRL_TX] & idle;
   wire start_rx = ctrl_hit & wdata_reg[CTRL_RX] & idle & ~start_tx;
   wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire w_known = waddr_reg == REG_CTRL | waddr_reg == REG_HEAD;
   wire [31:0] status = {27'h0, rx_mode_reg, aln_reg, ovf_reg, done_reg,
                         ~idle};
   wire r_known = s_axi_araddr_i <= REG_DESCS & s_axi_araddr_i[1:0] == 2'h0;
   wire [31:0] rd_mux =
      s_axi_araddr_i == REG_HEAD ? head_reg :
      s_axi_araddr_i == REG_STAT ? status :
      s_axi_araddr_i == REG_BYTES ? bytes_reg :
      s_axi_araddr_i == REG_DESCS ? descs_reg : 32'h0;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o <= 1'b1;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OK;
         waddr_reg <= 8'h0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         head_reg <= 32'h0;
      end else begin
         if (aw_hs) begin
            s_axi_awready_o <= 1'b0;
            waddr_reg <= s_axi_awaddr_i;
         end
         if (w_hs) begin
            s_axi_wready_o <= 1'b0;
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
         end
         if (commit) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= w_known ? RESP_OK : RESP_ERR;
            if (waddr_reg == REG_HEAD)
               head_reg <= (head_reg & ~wmask) | (wdata_reg & wmask);
         end
         if (s_axi_bvalid_o & s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0;
         s_axi_rresp_o <= RESP_OK;
      end else if (s_axi_arvalid_i & s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_mux;
         s_axi_rresp_o <= r_known ? RESP_OK : RESP_ERR;
      end else if (s_axi_rvalid_o & s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end
   // ****************************************
   // Chain engine
   // ****************************************
   logic [31:0] desc_reg, ptr_reg, link_reg, optr_reg;
   logic [31:0] w3_reg;
   logic [LEN_W-1:0] olen_reg, cnt_reg;
   logic [2:0] k_reg;
   logic fin_reg, last_reg, drop_reg;
   wire ack = mem_req_o & mem_ack_i;
   wire [31:0] k_ofs = {27'h0, k_reg, 2'h0};
   wire [31:0] word_addr = desc_reg + OFS_W3 + k_ofs;
   wire [LEN_W-1:0] cnt_inc = cnt_reg + 1'b1;
   wire [LEN_W-1:0] tx_len = w3_reg[LEN_W-1:0];
   wire [31:0] ptr_inc = ptr_reg + 32'h1;
   wire [4:0] lane_sh = {ptr_reg[1:0], 3'h0};
   wire [31:0] lane_rd = mem_rdata_i >> lane_sh;
   wire [31:0] lane_wr = {24'h0, rx_data_i} << lane_sh;
   wire [3:0] lane_be = 4'h1 << ptr_reg[1:0];
   wire link_ok = link_reg[1:0] == 2'h0; // see [R13]
   wire rx_take = rx_valid_i & rx_ready_o;
   wire [31:0] wb_word = k_reg == K_W3 ? {w3_reg[31:RSV_LSB], cnt_reg} :
                         k_reg == K_W4 ? optr_reg :
                         fin_reg ? 32'h0 : link_reg;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_reg <= S_IDLE;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= 32'h0;
         mem_wdata_o <= 32'h0;
         mem_be_o <= 4'h0;
         tx_valid_o <= 1'b0;
         tx_data_o <= 8'h0;
         tx_last_o <= 1'b0;
         rx_ready_o <= 1'b0;
         {desc_reg, ptr_reg, link_reg, optr_reg, w3_reg} <= '0;
         {olen_reg, cnt_reg, k_reg} <= '0;
         {fin_reg, last_reg, drop_reg, rx_mode_reg} <= '0;
         {done_reg, ovf_reg, aln_reg} <= '0;
         bytes_reg <= 32'h0;
         descs_reg <= 32'h0;
      end else begin
         if (ack)
            mem_req_o <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (start_tx | start_rx) begin
                  rx_mode_reg <= start_rx;
                  {done_reg, ovf_reg, aln_reg} <= 3'h0;
                  bytes_reg <= 32'h0;
                  descs_reg <= 32'h0;
                  if (head_reg[1:0] != 2'h0) begin
                     aln_reg <= 1'b1;
                     done_reg <= 1'b1;
                  end else begin
                     desc_reg <= head_reg; // see [R12]
                     k_reg <= K_W3;
                     state_reg <= S_DESC;
                  end
               end
            end
            S_DESC: begin
               if (!mem_req_o) begin
                  mem_req_o <= 1'b1;
                  mem_we_o <= 1'b0;
                  mem_be_o <= 4'hf;
                  mem_addr_o <= word_addr;
               end else if (ack) begin
                  case (k_reg)
                     K_W3: w3_reg <= mem_rdata_i;
                     K_W4: ptr_reg <= mem_rdata_i; // see [R4]
                     K_W5: link_reg <= mem_rdata_i;
                     // Pool and count bits dropped; see [R10] [R11]
                     K_W6: olen_reg <= mem_rdata_i[LEN_W-1:0]; // see [R8]
                     default: optr_reg <= mem_rdata_i; // see [R9]
                  endcase
                  k_reg <= k_reg + 3'h1;
                  if (k_reg == K_W7) begin
                     descs_reg <= descs_reg + 32'h1;
                     cnt_reg <= '0;
                     fin_reg <= 1'b0;
                     state_reg <= S_MOVE;
                     if (rx_mode_reg) begin
                        ptr_reg <= mem_rdata_i; // see [R5]
                        rx_ready_o <= olen_reg != '0;
                     end
                  end
               end
            end
            S_MOVE: begin
               if (!rx_mode_reg) begin
                  // Transmit: pointer marks first valid byte; see [R2]
                  if (cnt_reg == tx_len && !tx_valid_o && !mem_req_o) begin
                     if (link_reg == 32'h0 || !link_ok) begin // see [R7]
                        aln_reg <= !link_ok;
                        done_reg <= 1'b1;
                        state_reg <= S_IDLE;
                     end else begin
                        desc_reg <= link_reg;
                        k_reg <= K_W3;
                        state_reg <= S_DESC;
                     end
                  end else if (!tx_valid_o && !mem_req_o) begin
                     mem_req_o <= 1'b1;
                     mem_we_o <= 1'b0;
                     mem_be_o <= lane_be;
                     mem_addr_o <= {ptr_reg[31:2], 2'h0};
                  end else if (ack) begin
                     tx_valid_o <= 1'b1;
                     tx_data_o <= lane_rd[7:0];
                     tx_last_o <= cnt_inc == tx_len && link_reg == 32'h0;
                  end else if (tx_valid_o && tx_ready_i) begin
                     tx_valid_o <= 1'b0;
                     tx_last_o <= 1'b0;
                     cnt_reg <= cnt_inc;
                     ptr_reg <= ptr_inc;
                     bytes_reg <= bytes_reg + 32'h1;
                  end
               end else if (rx_take) begin
                  rx_ready_o <= 1'b0;
                  last_reg <= rx_last_i;
                  mem_req_o <= 1'b1;
                  mem_we_o <= 1'b1;
                  mem_be_o <= lane_be;
                  mem_addr_o <= {ptr_reg[31:2], 2'h0};
                  mem_wdata_o <= lane_wr;
               end else if (ack || olen_reg == '0) begin
                  if (ack) begin
                     cnt_reg <= cnt_inc;
                     ptr_reg <= ptr_inc;
                     bytes_reg <= bytes_reg + 32'h1;
                  end
                  k_reg <= K_W3;
                  if (ack && last_reg) begin
                     fin_reg <= 1'b1;
                     state_reg <= S_WBACK;
                  end else if (!ack || cnt_inc == olen_reg) begin // see [R14]
                     drop_reg <= link_reg == 32'h0 || !link_ok;
                     ovf_reg <= link_reg == 32'h0;
                     aln_reg <= !link_ok;
                     fin_reg <= link_reg == 32'h0 || !link_ok;
                     state_reg <= S_WBACK;
                  end else
                     rx_ready_o <= 1'b1;
               end
            end
            S_WBACK: begin
               // Only words three to five are written; see [R8] [R9]
               if (!mem_req_o) begin
                  mem_req_o <= 1'b1;
                  mem_we_o <= 1'b1;
                  mem_be_o <= 4'hf;
                  mem_addr_o <= word_addr;
                  mem_wdata_o <= wb_word; // see [R1] [R3] [R5] [R6]
               end else if (ack) begin
                  k_reg <= k_reg + 3'h1;
                  if (k_reg == K_W5) begin
                     if (drop_reg) begin
                        rx_ready_o <= 1'b1;
                        state_reg <= S_DROP;
                     end else if (fin_reg) begin
                        done_reg <= 1'b1;
                        state_reg <= S_IDLE;
                     end else begin
                        desc_reg <= link_reg;
                        k_reg <= K_W3;
                        state_reg <= S_DESC;
                     end
                  end
               end
            end
            S_DROP: begin
               if (rx_take && rx_last_i) begin
                  rx_ready_o <= 1'b0;
                  drop_reg <= 1'b0;
                  done_reg <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire wb_req = state_reg == S_WBACK && mem_req_o;

   mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> // see [R4]
      mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
      else $error("memory request dropped before ack");
   wb_span_a: assert property (wb_req |-> mem_we_o && // see [R8]
      mem_addr_o - desc_reg >= OFS_W3 && mem_addr_o - desc_reg < 32'h18)
      else $error("write-back outside words three to five");
   len_wb_a: assert property (wb_req && k_reg == K_W3 |-> // see [R1]
      mem_wdata_o[LEN_W-1:0] == cnt_reg)
      else $error("length write-back differs from count");
   rsv_keep_a: assert property (wb_req && k_reg == K_W3 |-> // see [R3]
      mem_wdata_o[31:RSV_LSB] == w3_reg[31:RSV_LSB])
      else $error("reserved bits of word three changed");
   ptr_wb_a: assert property (wb_req && k_reg == K_W4 |-> // see [R5]
      mem_wdata_o == optr_reg)
      else $error("pointer write-back is not the buffer address");
   link_end_a: assert property (wb_req && k_reg == K_W5 && fin_reg |->
      mem_wdata_o == 32'h0) // see [R7]
      else $error("final buffer link not zero");
   rx_limit_a: assert property (rx_mode_reg && state_reg == S_MOVE |->
      cnt_reg <= olen_reg) // see [R14]
      else $error("receive passed original length");
   tx_last_a: assert property (tx_valid_o && tx_last_o |-> // see [R7]
      link_reg == 32'h0 && cnt_inc == tx_len)
      else $error("last flag on a non-final byte");
   tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> // see [R2]
      tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
      else $error("transmit byte changed while stalled");
   bus_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");

   tx_pkt_c: cover property (tx_valid_o && tx_ready_i && tx_last_o);
   rx_chain_c: cover property (state_reg == S_WBACK && !fin_reg ##[1:200]
      state_reg == S_DESC);
   rx_ovf_c: cover property (state_reg == S_DROP);
endmodule

//--- tb/bdc_mem_model.sv
/*
 Behavioural shared memory that holds descriptors and buffers.
 Assumes one held request at a time, answered by a one-cycle ack.
*/
`timescale 1ns/1ps
module bdc_mem_model (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic [31:0] mem_wdata_i,
   input wire logic [3:0] mem_be_i,
   input wire logic [1:0] dly_i,
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o
);
   // ****
   // Storage, 32-byte descriptors on word slots
   // ****
   logic [31:0] mem [0:255];
   logic [1:0] cnt;
   wire [7:0] idx = mem_addr_i[9:2];
   // Pool and count bits change only through tb writes
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         mem_ack_o <= 1'b0;
         cnt <= 2'h0;
         mem_rdata_o <= 32'h5a5a5a5a;
      end else if (mem_ack_o) begin
         mem_ack_o <= 1'b0;
         cnt <= 2'h0;
         mem_rdata_o <= ~mem_rdata_o;
      end else if (mem_req_i && cnt == dly_i) begin
         mem_ack_o <= 1'b1;
         mem_rdata_o <= mem_we_i ? ~mem_rdata_o : mem[idx];
         for (int i = 0; i < 4; i++) begin
            if (mem_we_i && mem_be_i[i]) begin
               mem[idx][8*i+:8] <= mem_wdata_i[8*i+:8];
            end
         end
      end else begin
         cnt <= mem_req_i ? cnt + 2'h1 : 2'h0;
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule

//--- tb/buffer_descriptor_chain_handler_tb.sv
/*
 Testbench for the chain engine: AXI4-Lite register tasks, transmit
 and receive chains through a memory model.
 Assumes the engine in logic/ and the memory model in tb/.
*/
`timescale 1ns/1ps
module buffer_descriptor_chain_handler_tb;
   import bdc_pkg::*;
   logic clock_i = 0, sys_rst_i = 1;
   logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
   logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
   logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, mem_addr_o, mem_wdata_o;
   logic [3:0] s_axi_wstrb_i = 4'hf, mem_be_o;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, dly = 0, r;
   logic s_axi_rvalid_o, mem_req_o, mem_we_o, mem_ack_i, tx_valid_o;
   logic [31:0] mem_rdata_i, d;
   logic [7:0] tx_data_o, rx_data_i = 0, rc = 0;
   logic tx_last_o, tx_ready_i = 0, rx_valid_i = 0, rx_last_i = 0;
   logic rx_ready_o;
   logic [8:0] txq [$];
   int fails = 0, checks_done = 0;
   bdc_chain u_dut (.*);
   bdc_mem_model u_mem (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
      .mem_wdata_i(mem_wdata_o), .mem_be_i(mem_be_o), .dly_i(dly),
      .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
   initial forever #10 clock_i = ~clock_i;
   // ****
   // Stalling sink, collects transmit bytes
   // ****
   always @(posedge clock_i) begin
      rc <= rc + 8'h1;
      tx_ready_i <= rc[1] | rc[0];
      if (tx_valid_o && tx_ready_i) txq.push_back({tx_last_o, tx_data_o});
   end
   task check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task stop_test;
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= v;
      s_axi_awvalid_i <= 1;
      s_axi_wvalid_i <= 1;
      s_axi_bready_i <= 1;
      forever begin
         @(posedge clock_i);
         if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 0;
         if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 0;
         if (s_axi_bvalid_o) begin
            r = s_axi_bresp_o;
            s_axi_bready_i <= 0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1;
      s_axi_rready_i <= 1;
      forever begin
         @(posedge clock_i);
         if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 0;
         if (s_axi_rvalid_o) begin
            d = s_axi_rdata_o;
            r = s_axi_rresp_o;
            s_axi_rready_i <= 0;
            break;
         end
      end
   endtask
   task wait_idle;
      for (int n = 0; n < 300; n++) begin
         rd(REG_STAT);
         if (d[0] === 1'b0) break;
      end
   endtask
   task desc(input int a, input logic [31:0] w3, w4, w5, w6, w7);
      u_mem.mem[a/4+3] = w3;
      u_mem.mem[a/4+4] = w4;
      u_mem.mem[a/4+5] = w5;
      u_mem.mem[a/4+6] = w6;
      u_mem.mem[a/4+7] = w7;
   endtask
   task rx_put(input logic [7:0] b, input logic l);
      rx_valid_i <= 1;
      rx_data_i <= b;
      rx_last_i <= l;
      for (int n = 0; n < 200; n++) begin
         @(posedge clock_i);
         if (rx_ready_o === 1'b1) break;
      end
   endtask
   task rx_run(input logic [7:0] base, input int cnt);
      for (int i = 1; i <= cnt; i++) rx_put(base + 8'(i), i == cnt);
      rx_valid_i <= 0;
      wait_idle;
   endtask
   initial begin
      #200000;
      fails++;
      stop_test;
   end
   initial begin
      repeat (3) @(posedge clock_i);
      sys_rst_i <= 0;
      // ****
      // Registers and bus errors
      // ****
      rd(REG_STAT);
      check(d, 32'h0);
      wr(REG_HEAD, 32'h00000100);
      rd(REG_HEAD);
      check(d, 32'h00000100);
      rd(8'h14);
      check({30'h0, r}, {30'h0, RESP_ERR});
      wr(8'h14, 32'h1);
      check({30'h0, r}, {30'h0, RESP_ERR});
      // ****
      // Transmit chain of two buffers
      // ****
      desc(32'h100, 32'hffc00003, 32'h201, 32'h120, 32'ha5400003, 32'h201);
      desc(32'h120, 32'h00000002, 32'h240, 32'h0, 32'hffc00002, 32'h240);
      u_mem.mem[32'h200/4] = 32'h44332211;
      u_mem.mem[32'h240/4] = 32'h77886655;
      wr(REG_CTRL, 32'h1);
      wait_idle;
      check(d, 32'h2);
      check(32'(txq.size()), 5);
      foreach (txq[i]) check(32'(txq[i]), 32'(i == 4) << 8 | 32'h22 + 32'h11 * i);
      rd(REG_BYTES);
      check(d, 32'd5);
      rd(REG_DESCS);
      check(d, 32'd2);
      // ****
      // Receive over two buffers, slow memory
      // ****
      dly = 2'h2;
      desc(32'h140, 32'ha9400005, 32'hdead0000, 32'h160, 32'h50c00003, 32'h281);
      desc(32'h160, 32'h0, 32'h0, 32'h180, 32'h00000004, 32'h2c0);
      u_mem.mem[32'h280/4] = 32'h000000ee;
      u_mem.mem[32'h2c0/4] = 32'hffffffff;
      wr(REG_HEAD, 32'h140);
      wr(REG_CTRL, 32'h2);
      rx_run(8'ha0, 5);
      check(d, 32'h12);
      check(u_mem.mem[32'h140/4+3], 32'ha9400003);
      check(u_mem.mem[32'h140/4+4], 32'h281);
      check(u_mem.mem[32'h140/4+5], 32'h160);
      check(u_mem.mem[32'h140/4+6], 32'h50c00003);
      check(u_mem.mem[32'h140/4+7], 32'h281);
      check(u_mem.mem[32'h160/4+3], 32'h2);
      check(u_mem.mem[32'h160/4+5], 32'h0);
      check(u_mem.mem[32'h280/4], 32'ha3a2a1ee);
      check(u_mem.mem[32'h2c0/4], 32'hffffa5a4);
      rd(REG_BYTES);
      check(d, 32'd5);
      // ****
      // Receive overflow of a short last buffer
      // ****
      dly = 2'h0;
      desc(32'h180, 32'h0, 32'h0, 32'h0, 32'hf0000002, 32'h300);
      u_mem.mem[32'h300/4] = 32'h0;
      u_mem.mem[32'h304/4] = 32'h0;
      wr(REG_HEAD, 32'h180);
      wr(REG_CTRL, 32'h2);
      rx_run(8'hb0, 4);
      check(d, 32'h16);
      check(u_mem.mem[32'h300/4], 32'h0000b2b1);
      check(u_mem.mem[32'h304/4], 32'h0);
      check(u_mem.mem[32'h180/4+3], 32'h2);
      check(u_mem.mem[32'h180/4+6], 32'hf0000002);
      // ****
      // Misaligned head
      // ****
      wr(REG_HEAD, 32'h102);
      wr(REG_CTRL, 32'h1);
      wait_idle;
      check({31'h0, d[3]}, 32'h1);
      stop_test;
   end
endmodule
